// file: core/apsw_core.sv
// ATX power and reset sequencer with host watchdog
`timescale 1ns/1ns
`default_nettype none
module apsw_core
	import apsw_pkg::*;
#(
	parameter int TICK_DIV = TICK_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire apsw_pkg::apsw_cmd_t cmd,
	output logic cmd_ready,
	output logic cmd_ack,
	input wire logic [7:0] boot_func_mask,
	input wire logic [7:0] boot_pulse_len,
	input wire logic host_sense_pin,
	input wire logic confirm_key_pin,
	input wire logic cancel_key_pin,
	output apsw_pkg::apsw_pin_t reset_pin,
	output apsw_pkg::apsw_pin_t power_pin,
	output logic display_blank,
	output logic backlight_off,
	output logic self_restart,
	output apsw_pkg::apsw_status_t status
);
	import apsw_pkg::*;

	initial begin
		if (TICK_DIV < 2) begin
			$error("apsw_core tick divider too small");
		end
	end

	// ==========================================================
	// Pin synchronisers
	logic [1:0] sense_sync;
	logic [1:0] confirm_sync;
	logic [1:0] cancel_sync;
	logic sense_prev;
	logic host_up;
	logic confirm_held;
	logic cancel_held;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sense_sync <= 2'h0;
			confirm_sync <= 2'h0;
			cancel_sync <= 2'h0;
			sense_prev <= 1'b0;
		end else begin
			sense_sync <= {sense_sync[0], host_sense_pin};
			confirm_sync <= {confirm_sync[0], confirm_key_pin};
			cancel_sync <= {cancel_sync[0], cancel_key_pin};
			sense_prev <= sense_sync[1];
		end
	end

	assign host_up = sense_sync[1];
	assign confirm_held = confirm_sync[1];
	assign cancel_held = cancel_sync[1];

	// ==========================================================
	// 1/32 s tick
	localparam int DIV_W = $clog2(TICK_DIV);
	logic [DIV_W-1:0] div_count;
	logic tick;

	always_ff @(posedge sys_clk) begin
		if (!nrst || tick) begin
			div_count <= '0;
		end else begin
			div_count <= div_count + 1'b1;
		end
	end

	assign tick = (div_count == DIV_W'(TICK_DIV - 1));

	// ==========================================================
	// Key hold detectors
	logic confirm_long;
	logic confirm_short;
	logic cancel_long;

	apsw_hold_timer #(.THRESHOLD(KEY_LONG_TICKS), .W(8)) u_confirm_long (
		.sys_clk(sys_clk), .nrst(nrst), .tick(tick),
		.held(confirm_held), .reached(confirm_long)
	);
	apsw_hold_timer #(.THRESHOLD(KEY_SHORT_TICKS), .W(8)) u_confirm_short (
		.sys_clk(sys_clk), .nrst(nrst), .tick(tick),
		.held(confirm_held), .reached(confirm_short)
	);
	apsw_hold_timer #(.THRESHOLD(KEY_LONG_TICKS), .W(8)) u_cancel_long (
		.sys_clk(sys_clk), .nrst(nrst), .tick(tick),
		.held(cancel_held), .reached(cancel_long)
	);

	// ==========================================================
	// Configuration and command intake
	apsw_state_t state;
	logic boot_load;
	logic [7:0] func_mask;
	logic [7:0] pulse_len;
	logic cmd_take;
	logic restart_req;
	logic blanked;

	assign cmd_ready = (state != ST_LOCKED) && !boot_load;
	assign cmd_take = cmd.valid && cmd_ready;

	// Boot config is caught one cycle after reset or restart, never inside reset
	always_ff @(posedge sys_clk) begin
		if (!nrst || restart_req) begin
			boot_load <= 1'b1;
		end else begin
			boot_load <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			func_mask <= FN_MASK_RESET;
			pulse_len <= PWR_PULSE_DEFAULT;
		end else if (boot_load) begin
			func_mask <= boot_func_mask;
			pulse_len <= (boot_pulse_len == 8'h00) ? PWR_PULSE_DEFAULT : boot_pulse_len;
		end else if (cmd_take && cmd.kind == CMD_ATX_CFG && cmd.len != 2'h0) begin
			func_mask <= cmd.data0;
			if (cmd.len == 2'h2 && cmd.data1 != 8'h00) begin
				pulse_len <= cmd.data1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			cmd_ack <= 1'b0;
		end else begin
			cmd_ack <= cmd_take;
		end
	end

	// ==========================================================
	// Watchdog
	logic [7:0] wd_count;
	logic [4:0] wd_sub;
	logic wd_fire;

	always_ff @(posedge sys_clk) begin
		if (!nrst || boot_load) begin
			wd_count <= 8'h00;
			wd_sub <= 5'h00;
			wd_fire <= 1'b0;
		end else if (cmd_take && cmd.kind == CMD_WATCHDOG) begin
			wd_count <= cmd.data0;
			wd_sub <= 5'h00;
			wd_fire <= 1'b0;
		end else begin
			wd_fire <= 1'b0;
			if (tick && wd_count != 8'h00) begin
				wd_sub <= wd_sub + 5'h01;
				if (wd_sub == 5'(TICKS_PER_SEC - 1)) begin
					wd_count <= wd_count - 8'h01;
					wd_fire <= (wd_count == 8'h01);
				end
			end
		end
	end

	// ==========================================================
	// Status answer
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			status <= '0;
		end else begin
			status.valid <= cmd_take && cmd.kind == CMD_STATUS;
			if (cmd_take && cmd.kind == CMD_STATUS) begin
				status.func_mask <= func_mask;
				status.wd_count <= wd_count;
			end
		end
	end

	// ==========================================================
	// Pulse sequencer
	logic [7:0] pulse_count;
	logic wd_pending;
	logic keys_spent;

	// Saturated hold timers would retrigger; both keys must be released first
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			keys_spent <= 1'b0;
		end else if (!confirm_held && !cancel_held) begin
			keys_spent <= 1'b0;
		end else if (state != ST_IDLE) begin
			keys_spent <= 1'b1;
		end
	end

	// Expiry during a power-off pulse waits for idle; one during a pulse that ends in ST_LOCKED is cleared by the restart
	always_ff @(posedge sys_clk) begin
		if (!nrst || boot_load) begin
			wd_pending <= 1'b0;
		end else if (wd_fire) begin
			wd_pending <= 1'b1;
		end else if (state == ST_IDLE) begin
			wd_pending <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst || boot_load) begin
			state <= ST_IDLE;
			pulse_count <= 8'h00;
		end else begin
			case (state)
				ST_IDLE: begin
					pulse_count <= 8'h00;
					if (wd_fire || wd_pending) begin
						state <= ST_RST_PULSE;
					end else if (keys_spent) begin
						state <= ST_IDLE;
					end else if (func_mask[FN_KEY_RESET] && host_up && confirm_long) begin
						state <= ST_RST_PULSE;
					end else if (func_mask[FN_KEY_POWER_ON] && !host_up && confirm_short) begin
						state <= ST_PWR_ON_PULSE;
					end else if (func_mask[FN_KEY_POWER_OFF] && host_up && cancel_long) begin
						state <= ST_PWR_OFF_PULSE;
					end
				end
				ST_RST_PULSE: begin
					if (tick) begin
						pulse_count <= pulse_count + 8'h01;
						if (pulse_count == 8'(RESET_PULSE_TICKS - 1)) begin
							state <= ST_LOCKED;
						end
					end
				end
				ST_LOCKED: begin
					state <= ST_LOCKED; // Left only through restart
				end
				ST_PWR_ON_PULSE, ST_PWR_OFF_PULSE: begin
					if (tick) begin
						pulse_count <= pulse_count + 8'h01;
						if (pulse_count == pulse_len - 8'h01) begin
							pulse_count <= 8'h00;
							if (state == ST_PWR_ON_PULSE) begin
								state <= ST_LOCKED;
							end else if (cancel_held) begin
								state <= ST_PWR_EXTEND;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
				end
				ST_PWR_EXTEND: begin
					if (!cancel_held) begin
						state <= ST_IDLE;
					end else if (tick) begin
						pulse_count <= pulse_count + 8'h01;
						if (pulse_count == 8'(PWR_EXTEND_TICKS - 1)) begin
							state <= ST_IDLE;
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Restart, display blanking and pin drive
	assign blanked = func_mask[FN_BLANK_DISPLAY] && !host_up;
	assign restart_req = self_restart;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			self_restart <= 1'b0;
			display_blank <= 1'b0;
			backlight_off <= 1'b0;
		end else begin
			// Locked state restarts self once the host pulse is over
			self_restart <= !self_restart && !boot_load && ((state == ST_LOCKED)
				|| (display_blank && host_up && !sense_prev));
			display_blank <= blanked && !boot_load;
			backlight_off <= blanked && !boot_load;
		end
	end

	// Output is the asserted level; the enable alone frees the line
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			reset_pin <= '0;
			power_pin <= '0;
		end else begin
			reset_pin.oe <= (state == ST_RST_PULSE);
			reset_pin.out <= func_mask[FN_RESET_POL];
			power_pin.oe <= (state == ST_PWR_ON_PULSE) || (state == ST_PWR_OFF_PULSE)
				|| (state == ST_PWR_EXTEND);
			power_pin.out <= func_mask[FN_POWER_POL];
		end
	end
endmodule
`default_nettype wire

// file: core/apsw_hold_timer.sv
// Key hold timer counting ticks while a key stays pressed
`timescale 1ns/1ns
`default_nettype none
module apsw_hold_timer #(
	parameter int THRESHOLD = 128,
	parameter int W = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic tick,
	input wire logic held,
	output logic reached
);
	logic [W-1:0] count;

	initial begin
		if (THRESHOLD < 1 || THRESHOLD >= (1 << W)) begin
			$error("apsw_hold_timer threshold does not fit");
		end
	end

	// Saturates at threshold so a long hold never wraps
	always_ff @(posedge sys_clk) begin
		if (!nrst || !held) begin
			count <= '0;
		end else if (tick && count != W'(THRESHOLD)) begin
			count <= count + W'(1);
		end
	end

	assign reached = held && (count == W'(THRESHOLD));
endmodule
`default_nettype wire

// file: core/apsw_pkg.sv
// Shared constants and types of the ATX power switch and watchdog block
package apsw_pkg;
	// ==========================================================
	// Clock and tick timing
	localparam int SYS_CLK_HZ = 25000000;
	localparam int TICK_HZ = 32;
	localparam int TICK_CYCLES = SYS_CLK_HZ / TICK_HZ;
	localparam int TICKS_PER_SEC = TICK_HZ;
	// Times in milliseconds, as figures; tick counts derived from them
	localparam int KEY_LONG_MS = 4000;
	localparam int KEY_SHORT_MS = 250;
	localparam int RESET_PULSE_MS = 1000;
	localparam int PWR_EXTEND_MS = 5000;
	localparam int KEY_LONG_TICKS = (KEY_LONG_MS * TICK_HZ + 999) / 1000;
	localparam int KEY_SHORT_TICKS = (KEY_SHORT_MS * TICK_HZ + 999) / 1000;
	localparam int RESET_PULSE_TICKS = (RESET_PULSE_MS * TICK_HZ + 999) / 1000;
	localparam int PWR_EXTEND_TICKS = PWR_EXTEND_MS * TICK_HZ / 1000;
	localparam logic [7:0] PWR_PULSE_DEFAULT = 8'h20;
	// ==========================================================
	// Command types and status layout
	localparam logic [7:0] CMD_ATX_CFG = 8'h1C;
	localparam logic [7:0] CMD_WATCHDOG = 8'h1D;
	localparam logic [7:0] CMD_STATUS = 8'h1E;
	localparam int STATUS_LEN = 15;
	localparam int STATUS_MASK_BYTE = 7;
	localparam int STATUS_WD_BYTE = 8;
	// ==========================================================
	// Function-enable mask bits
	localparam int FN_RESET_POL = 1;
	localparam int FN_POWER_POL = 2;
	localparam int FN_BLANK_DISPLAY = 4;
	localparam int FN_KEY_RESET = 5;
	localparam int FN_KEY_POWER_ON = 6;
	localparam int FN_KEY_POWER_OFF = 7;
	localparam logic [7:0] FN_MASK_RESET = 8'h00;
	// Pin configuration byte layout
	localparam int PINCFG_FUNC_BIT = 3;
	localparam int PINCFG_DRIVE_LSB = 0;
	localparam int PINCFG_DRIVE_W = 3;
	localparam logic [2:0] DRIVE_SENSE = 3'h3;
	localparam logic [2:0] DRIVE_HIZ = 3'h2;

	typedef struct packed {
		logic valid;
		logic [7:0] kind;
		logic [1:0] len;
		logic [7:0] data0;
		logic [7:0] data1;
	} apsw_cmd_t;

	typedef struct packed {
		logic out;
		logic oe;
	} apsw_pin_t;

	typedef struct packed {
		logic valid;
		logic [7:0] func_mask;
		logic [7:0] wd_count;
	} apsw_status_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RST_PULSE = 3'b001,
		ST_LOCKED = 3'b010,
		ST_PWR_ON_PULSE = 3'b011,
		ST_PWR_OFF_PULSE = 3'b100,
		ST_PWR_EXTEND = 3'b101
	} apsw_state_t;
endpackage

// file: verif/apsw_host_model.sv
// Behavioural host and ATX supply seen from the sequencer pins
`timescale 1ns/1ns
`default_nettype none
module apsw_host_model
	import apsw_pkg::*;
(
	input wire logic host_on,
	input wire apsw_pkg::apsw_pin_t reset_pin,
	input wire apsw_pkg::apsw_pin_t power_pin,
	output logic host_sense_pin,
	output logic reset_line,
	output logic power_line
);
	// Sense pulled up while the host runs, driven down when off
	assign host_sense_pin = host_on;
	// Host left both pins as inputs; supply pull-ups win when floating
	assign reset_line = reset_pin.oe ? reset_pin.out : 1'b1;
	assign power_line = power_pin.oe ? power_pin.out : 1'b1;
endmodule
`default_nettype wire

// file: verif/apsw_props.sv
// Assertion checker for the ATX power switch and watchdog block
`timescale 1ns/1ns
`default_nettype none
module apsw_props
	import apsw_pkg::*;
#(
	parameter int TICK_DIV = 4
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire apsw_pkg::apsw_cmd_t cmd,
	input wire logic cmd_ready,
	input wire logic cmd_ack,
	input wire logic host_sense_pin,
	input wire apsw_pkg::apsw_pin_t reset_pin,
	input wire apsw_pkg::apsw_pin_t power_pin,
	input wire logic display_blank,
	input wire logic backlight_off,
	input wire logic self_restart,
	input wire apsw_pkg::apsw_status_t status
);
	// ==========================================
	// Pulse run counters; tick alignment costs a tick either way
	localparam int RST_MIN = 31 * TICK_DIV;
	localparam int RST_MAX = 34 * TICK_DIV;
	localparam int PWR_MAX = 418 * TICK_DIV;
	logic [15:0] rst_run;
	logic [15:0] pwr_run;
	always_ff @(posedge sys_clk) begin
		rst_run <= (!nrst || !reset_pin.oe) ? 16'h0 : rst_run + 16'h1;
	end
	always_ff @(posedge sys_clk) begin
		pwr_run <= (!nrst || !power_pin.oe) ? 16'h0 : pwr_run + 16'h1;
	end
	// ==========================================
	// Properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_take;
		cmd.valid && cmd_ready;
	endsequence
	sequence s_boot_load;
		!cmd_ready ##1 cmd_ready;
	endsequence
	sequence s_restart_done;
		##[0:4] self_restart ##1 1'b1;
	endsequence
	a_ack_take: assert property (cmd_ack == $past(cmd.valid && cmd_ready))
		else $error("ack does not match take");
	a_boot_load: assert property ($rose(nrst) |-> s_boot_load)
		else $error("boot load cycle wrong");
	a_rst_len: assert property ($fell(reset_pin.oe) |-> rst_run >= RST_MIN && rst_run <= RST_MAX)
		else $error("reset pulse length wrong");
	a_pwr_max: assert property (pwr_run <= PWR_MAX)
		else $error("power pulse too long");
	a_lock_restart: assert property ($fell(reset_pin.oe) |-> !cmd_ready throughout s_restart_done)
		else $error("commands taken before restart");
	a_blank_pair: assert property (display_blank == backlight_off)
		else $error("blank and backlight differ");
	a_blank_restart: assert property ($rose(host_sense_pin) && display_blank |-> ##[1:8] self_restart)
		else $error("no restart on sense rise");
	a_status_resp: assert property (s_take ##0 cmd.kind == CMD_STATUS |=> status.valid)
		else $error("status answer missing");
endmodule
bind apsw_core apsw_props #(.TICK_DIV(TICK_DIV)) u_props (.sys_clk(sys_clk), .nrst(nrst),
	.cmd(cmd), .cmd_ready(cmd_ready), .cmd_ack(cmd_ack), .host_sense_pin(host_sense_pin),
	.reset_pin(reset_pin), .power_pin(power_pin), .display_blank(display_blank),
	.backlight_off(backlight_off), .self_restart(self_restart), .status(status));
`default_nettype wire

// file: verif/atx_power_switch_watchdog_tb.sv
// Self-checking bench for the ATX power switch and watchdog block
`timescale 1ns/1ns
`default_nettype none
module atx_power_switch_watchdog_tb;
	import apsw_pkg::*;
	localparam int T = 4;
	logic sys_clk, nrst, confirm, cancel, host_on, sense, rline, pline;
	logic cmd_ready, cmd_ack, display_blank, backlight_off, self_restart;
	apsw_cmd_t cmd;
	apsw_pin_t reset_pin, power_pin;
	apsw_status_t status;
	int mismatches, n_checks, n;
	// Boot config stands for what the host saved
	apsw_core #(.TICK_DIV(T)) DUT (.sys_clk(sys_clk), .nrst(nrst), .cmd(cmd),
		.cmd_ready(cmd_ready), .cmd_ack(cmd_ack), .boot_func_mask(8'hE0),
		.boot_pulse_len(8'h04), .host_sense_pin(sense), .confirm_key_pin(confirm),
		.cancel_key_pin(cancel), .reset_pin(reset_pin), .power_pin(power_pin),
		.display_blank(display_blank), .backlight_off(backlight_off),
		.self_restart(self_restart), .status(status));
	apsw_host_model host (.host_on(host_on), .reset_pin(reset_pin), .power_pin(power_pin),
		.host_sense_pin(sense), .reset_line(rline), .power_line(pline));
	// ==========================================
	// Shared tasks
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic judge(input bit ok);
		n_checks++;
		if (!ok) begin
			mismatches++;
			$display("Error at %0t: unexpected result", $time);
		end
	endtask
	task automatic guard(input int i);
		if (i > 2000) begin
			mismatches++;
			conclude();
		end
	endtask
	// Counts cycles until the chosen enable reaches the level
	task automatic wait_oe(input bit rst, input logic lvl);
		n = 0;
		while ((rst ? reset_pin.oe : power_pin.oe) !== lvl) begin
			@(negedge sys_clk);
			n++;
			guard(n);
		end
	endtask
	task automatic send(input logic [7:0] k, input logic [1:0] l, input logic [7:0] d0);
		int i;
		i = 0;
		@(posedge sys_clk) cmd <= '{1'b1, k, l, d0, 8'h00};
		@(negedge sys_clk);
		while (cmd_ready !== 1'b1) begin
			@(negedge sys_clk);
			i++;
			guard(i);
		end
		@(posedge sys_clk) cmd.valid <= 1'b0;
		@(negedge sys_clk);
		judge(cmd_ack === 1'b1);
	endtask
	task automatic query(input logic [7:0] m, input logic [7:0] w);
		send(CMD_STATUS, 2'd0, 8'h00);
		judge(status.valid === 1'b1 && status.func_mask === m && status.wd_count === w);
	endtask
	// ==========================================
	// Scenarios
	task automatic t_boot;
		query(8'hE0, 8'h00);
		judge(rline === 1'b1 && pline === 1'b1);
		send(CMD_ATX_CFG, 2'd1, 8'h26);
		query(8'h26, 8'h00);
	endtask
	task automatic t_key_reset;
		@(posedge sys_clk) confirm <= 1'b1;
		repeat (100 * T) @(negedge sys_clk);
		@(posedge sys_clk) confirm <= 1'b0;
		repeat (8) @(negedge sys_clk);
		judge(reset_pin.oe === 1'b0);
		@(posedge sys_clk) confirm <= 1'b1;
		wait_oe(1'b1, 1'b1);
		judge(n >= 124 * T && n <= 132 * T);
		judge(rline === 1'b1 && reset_pin.out === 1'b1);
		@(posedge sys_clk) confirm <= 1'b0;
		wait_oe(1'b1, 1'b0);
		judge(n >= 31 * T && n <= 34 * T);
		judge(cmd_ready === 1'b0);
		query(8'hE0, 8'h00);
	endtask
	task automatic t_power;
		@(posedge sys_clk) host_on <= 1'b0;
		repeat (4) @(negedge sys_clk);
		@(posedge sys_clk) confirm <= 1'b1;
		wait_oe(1'b0, 1'b1);
		judge(n >= 7 * T && n <= 11 * T && pline === 1'b0);
		@(posedge sys_clk) confirm <= 1'b0;
		wait_oe(1'b0, 1'b0);
		judge(n >= 3 * T && n <= 6 * T);
		query(8'hE0, 8'h00);
		@(posedge sys_clk) host_on <= 1'b1;
		@(posedge sys_clk) cancel <= 1'b1;
		wait_oe(1'b0, 1'b1);
		judge(n >= 124 * T && n <= 132 * T);
		wait_oe(1'b0, 1'b0);
		judge(n >= 162 * T && n <= 167 * T);
		repeat (8 * T) @(negedge sys_clk);
		judge(power_pin.oe === 1'b0);
		@(posedge sys_clk) cancel <= 1'b0;
	endtask
	task automatic t_watchdog;
		send(CMD_WATCHDOG, 2'd1, 8'h02);
		query(8'hE0, 8'h02);
		send(CMD_WATCHDOG, 2'd1, 8'h00);
		repeat (80 * T) @(negedge sys_clk);
		judge(reset_pin.oe === 1'b0);
		send(CMD_WATCHDOG, 2'd1, 8'h01);
		wait_oe(1'b1, 1'b1);
		judge(n >= 30 * T && n <= 34 * T);
		wait_oe(1'b1, 1'b0);
		query(8'hE0, 8'h00);
	endtask
	task automatic t_blank;
		send(CMD_ATX_CFG, 2'd1, 8'h10);
		@(posedge sys_clk) host_on <= 1'b0;
		repeat (8) @(negedge sys_clk);
		judge(display_blank === 1'b1 && backlight_off === 1'b1);
		@(posedge sys_clk) host_on <= 1'b1;
		n = 0;
		while (self_restart !== 1'b1) begin
			@(negedge sys_clk);
			n++;
			guard(n);
		end
		judge(n < 8);
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		nrst = 1'b0;
		cmd = '0;
		confirm = 1'b0;
		cancel = 1'b0;
		host_on = 1'b1;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		t_boot();
		t_key_reset();
		t_power();
		t_watchdog();
		t_blank();
		conclude();
	end
endmodule
`default_nettype wire
